// [hdl/sensor_filter_pkg.sv]
// constants, field layouts and codes for the measurement filter block
// assumes a 50 MHz mclk and 32-bit AXI4-Lite register access
package sensor_filter_pkg;
  localparam logic [7:0] OFF_CARRIER = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_AVG_MODE = 8'h08;
  localparam logic [7:0] OFF_INT_TIME = 8'h0c;
  localparam logic [7:0] OFF_INT_MODE = 8'h10;
  localparam logic [7:0] OFF_RES = 8'h14;
  localparam logic [7:0] OFF_VID = 8'h18;
  localparam logic [7:0] OFF_FUNC = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_CORR = 8'h24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STRB_ALL = 4'hf;
  // carrier frequency in Hz
  localparam logic [31:0] CARRIER_HZ_SETTING_MIN = 32'h0bebc200;
  localparam logic [31:0] CARRIER_HZ_SETTING_MAX = 32'hee6b2800;
  localparam logic [31:0] CARRIER_HZ_SETTING_DEF = 32'h3b9aca00;
  // integration time in microseconds
  localparam logic [16:0] INT_MIN_US = 17'h01388;
  localparam logic [16:0] INT_MAX_US = 17'h1b1fc;
  localparam logic [16:0] INT_DEF_US = 17'h09088;
  localparam logic [8:0] CNT_DEF = 9'h001;
  localparam logic [3:0] LOG_MAX = 4'h8;
  localparam logic MODE_AUTO = 1'b0;
  localparam logic MODE_USER = 1'b1;
  localparam logic INT_DEF = 1'b0;
  localparam logic INT_USER = 1'b1;
  localparam logic RES_LOW = 1'b0;
  localparam logic RES_HIGH = 1'b1;
  // video bandwidth in Hz
  localparam logic [31:0] VID_4K_HZ = 32'h00000fa0;
  localparam logic [31:0] VID_200K_HZ = 32'h00030d40;
  localparam logic [31:0] VID_4M_HZ = 32'h003d0900;
  localparam logic [31:0] VID_600K_HZ = 32'h000927c0;
  localparam logic LOW_RANGE_VARIANT = 1'b0;
  typedef enum logic [1:0] {
    vid_narrow = 2'h0, vid_medium = 2'h1, vid_wide = 2'h2
  } vid_t;
  typedef enum logic [2:0] {
    mean_forward_power = 3'h0, computed_burst_mean = 3'h1,
    exceedance_probability = 3'h2, peak_to_mean_ratio = 3'h3,
    sensed_burst_mean = 3'h4, envelope_peak = 3'h5
  } func_t;
  localparam logic [2:0] FUNC_LAST = 3'h5;
  // automatic averaging: level thresholds and log2 steps
  localparam logic [15:0] PWR_HI_TH = 16'h4000;
  localparam logic [15:0] PWR_MID_TH = 16'h0800;
  localparam logic [3:0] AUTO_MID_LOG = 4'h2;
  localparam logic [3:0] AUTO_LOW_LOG = 4'h4;
  localparam logic [3:0] AUTO_RES_STEP = 4'h2;
  localparam logic [3:0] AUTO_STEP = 4'h1;
  // frequency correction, Q2.14 factors every 2^29 Hz
  localparam int CORR_FRAC = 14;
  localparam int SEG_FRAC_W = 8;
  localparam logic [15:0] CORR_TAB [0:8] = '{16'h4000, 16'h4040,
    16'h4080, 16'h40c0, 16'h4100, 16'h4180, 16'h4200, 16'h4280, 16'h4300};
  localparam int ST_LOG_MSB = 3;
  localparam int ST_FULL_BIT = 4;
  localparam int ST_MODE_BIT = 5;
  localparam int ST_INT_BIT = 6;
endpackage

// [hdl/power_sensor_filter_control.sv]
// measurement conditioning: settings, running average, carrier_hz_setting correction
// assumes samples arrive on mclk from the converter logic, one per pulse
// Function
// - correct forward and reverse results using carrier, interpolate linearly
// - free-running running average, one output per sample once the window is full, oldest dropped
// - only counts 1..256 in powers of two accepted, default 1
// - count one means each sample is output immediately
// - valid count entry applies to all paths and selects user mode
// - auto mode picks count from power, function, time, resolution
// - user mode uses the last entered count everywhere
// - integration time default 0.037 s or user value, default at start
// - integration time 5e-3 to 0.1111 s accepted, selects user mode
// - shorter time with averaging active raises automatic count
// - resolution low or high; any accepted resolution write selects auto mode
// - result format fixed whatever the resolution; host trims digits
// - video bandwidth 4e3, 2e5 or 4e6 Hz, default 2e5
// - forward function one of six choices, average by default
//
// The address map and the AXI4-Lite slave port were left to the implementer.
module power_sensor_filter_control
  import sensor_filter_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic sample_valid,
  input wire logic [15:0] fwd_sample,
  input wire logic [15:0] rev_sample,
  output logic out_valid,
  output logic [15:0] fwd_result,
  output logic [15:0] rev_result,
  output logic [16:0] adc_window_us,
  output logic [1:0] detector_bandwidth_select,
  output logic [2:0] forward_function
);
  function automatic logic is_pow2(input logic [31:0] c);
    return (c != 32'h0) && ((c & (c - 32'h1)) == 32'h0)
      && (c <= 32'h100);
  endfunction
  function automatic logic [3:0] cnt_log2(input logic [8:0] c);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 9; i++) begin
      if (c[i]) r = 4'(i);
    end
    return r;
  endfunction
  function automatic logic [15:0] apply_corr(input logic [15:0] v,
                                             input logic [15:0] k);
    logic [31:0] s;
    s = (32'(v) * 32'(k)) >> CORR_FRAC;
    return (s[31:16] != 16'h0) ? 16'hffff : s[15:0];
  endfunction

  // bus handshake state
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic do_write;
  // settings
  logic [31:0] carrier_hz_setting_reg, carrier_hz_setting_next;
  logic [8:0] smoothing_count_reg, smoothing_count_next;
  logic smoothing_mode_select_reg, smoothing_mode_select_next;
  logic [16:0] adc_window_time_reg, adc_window_time_next;
  logic adc_window_mode_reg, adc_window_mode_next;
  logic digit_precision_select_reg, digit_precision_select_next;
  vid_t vid_reg, vid_next;
  func_t func_reg, func_next;
  logic wr_err;
  // filter path
  logic [15:0] fwd_mem [0:255];
  logic [15:0] rev_mem [0:255];
  logic [3:0] eff_log_reg, eff_log_next, eff_log, auto_log;
  logic [7:0] ptr_reg, ptr_next;
  logic [8:0] fill_reg, fill_next;
  logic [23:0] fsum_reg, fsum_next, rsum_reg, rsum_next;
  logic out_valid_reg, out_valid_next;
  logic [15:0] fwd_res_reg, fwd_res_next, rev_res_reg, rev_res_next;
  logic [15:0] fwd_level_reg, fwd_level_next;
  logic [15:0] corr_reg, corr_next;
  logic [16:0] eff_time;
  logic window_full;

  assign awready = !aw_held_reg;
  assign wready = !w_held_reg;
  assign arready = !rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  // address and data may arrive in either order; both are parked
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (awvalid && awready) begin
      aw_held_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_held_next = 1'b1;
      w_data_next = wdata;
      w_strb_next = wstrb;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h0;
      unique case (araddr)
        OFF_CARRIER: rdata_next = carrier_hz_setting_reg;
        OFF_COUNT: rdata_next = 32'(smoothing_count_reg);
        OFF_AVG_MODE: rdata_next = 32'(smoothing_mode_select_reg);
        OFF_INT_TIME: rdata_next = 32'(adc_window_time_reg);
        OFF_INT_MODE: rdata_next = 32'(adc_window_mode_reg);
        OFF_RES: rdata_next = 32'(digit_precision_select_reg);
        OFF_VID: rdata_next = 32'(vid_reg);
        OFF_FUNC: rdata_next = 32'(func_reg);
        OFF_STATUS: begin
          rdata_next[ST_LOG_MSB:0] = eff_log_reg;
          rdata_next[ST_FULL_BIT] = window_full;
          rdata_next[ST_MODE_BIT] = smoothing_mode_select_reg;
          rdata_next[ST_INT_BIT] = adc_window_mode_reg;
        end
        OFF_CORR: rdata_next = 32'(corr_reg);
        default: rresp_next = RESP_SLVERR;
      endcase
    end else if (rready) begin
      rvalid_next = 1'b0;
    end
  end

  // settings; a refused value leaves every setting as it was
  always_comb begin
    carrier_hz_setting_next = carrier_hz_setting_reg;
    smoothing_count_next = smoothing_count_reg;
    smoothing_mode_select_next = smoothing_mode_select_reg;
    adc_window_time_next = adc_window_time_reg;
    adc_window_mode_next = adc_window_mode_reg;
    digit_precision_select_next = digit_precision_select_reg;
    vid_next = vid_reg;
    func_next = func_reg;
    wr_err = 1'b0;
    if (do_write && (w_strb_reg != STRB_ALL)) begin
      wr_err = 1'b1;
    end else if (do_write) begin
      unique case (aw_addr_reg)
        OFF_CARRIER:
          if (w_data_reg >= CARRIER_HZ_SETTING_MIN && w_data_reg <= CARRIER_HZ_SETTING_MAX)
            carrier_hz_setting_next = w_data_reg;
          else wr_err = 1'b1;
        OFF_COUNT:
          if (is_pow2(w_data_reg)) begin
            smoothing_count_next = w_data_reg[8:0];
            smoothing_mode_select_next = MODE_USER;
          end else wr_err = 1'b1;
        OFF_AVG_MODE:
          if (w_data_reg[31:1] == 31'h0)
            smoothing_mode_select_next = w_data_reg[0];
          else wr_err = 1'b1;
        OFF_INT_TIME:
          if (w_data_reg >= 32'(INT_MIN_US) &&
              w_data_reg <= 32'(INT_MAX_US)) begin
            adc_window_time_next = w_data_reg[16:0];
            adc_window_mode_next = INT_USER;
          end else wr_err = 1'b1;
        OFF_INT_MODE:
          if (w_data_reg[31:1] == 31'h0)
            adc_window_mode_next = w_data_reg[0];
          else wr_err = 1'b1;
        OFF_RES:
          if (w_data_reg[31:1] == 31'h0) begin
            digit_precision_select_next = w_data_reg[0];
            smoothing_mode_select_next = MODE_AUTO;
          end else wr_err = 1'b1;
        OFF_VID:
          if (w_data_reg == VID_4K_HZ) vid_next = vid_narrow;
          else if (w_data_reg == VID_200K_HZ) vid_next = vid_medium;
          else if (w_data_reg == (LOW_RANGE_VARIANT ? VID_600K_HZ :
                   VID_4M_HZ)) vid_next = vid_wide;
          else wr_err = 1'b1;
        OFF_FUNC:
          if (w_data_reg <= 32'(FUNC_LAST))
            func_next = func_t'(w_data_reg[2:0]);
          else wr_err = 1'b1;
        default: wr_err = 1'b1;
      endcase
    end
  end

  assign eff_time = (adc_window_mode_reg == INT_USER) ?
    adc_window_time_reg : INT_DEF_US;

  // automatic count: weaker signal, higher resolution, any function but mean_forward_power
  // and a shortened window (when averaging already) all lengthen the average
  always_comb begin
    logic [3:0] a;
    a = (fwd_level_reg >= PWR_HI_TH) ? 4'h0 :
        (fwd_level_reg >= PWR_MID_TH) ? AUTO_MID_LOG : AUTO_LOW_LOG;
    if (digit_precision_select_reg == RES_HIGH)
      a = a + AUTO_RES_STEP;
    if (func_reg != mean_forward_power)
      a = a + AUTO_STEP;
    if (eff_time < INT_DEF_US && a != 4'h0)
      a = a + AUTO_STEP;
    auto_log = (a > LOG_MAX) ? LOG_MAX : a;
  end

  assign eff_log = (smoothing_mode_select_reg == MODE_USER) ?
    cnt_log2(smoothing_count_reg) : auto_log;
  assign window_full = fill_reg >= (9'h001 << eff_log_reg);

  // linear interpolation between neighbouring factors
  always_comb begin
    logic [2:0] seg;
    logic [15:0] lo, hi;
    logic signed [16:0] d;
    logic signed [25:0] pr;
    seg = carrier_hz_setting_reg[31:29];
    lo = CORR_TAB[seg];
    hi = CORR_TAB[4'(seg) + 4'h1];
    d = $signed({1'b0, hi}) - $signed({1'b0, lo});
    pr = d * $signed({1'b0, carrier_hz_setting_reg[28:21]});
    corr_next = 16'($signed({1'b0, lo}) + (pr >>> SEG_FRAC_W));
  end

  // a change of count restarts the window rather than mixing lengths
  always_comb begin
    logic [8:0] n, fill_b;
    logic [23:0] fs_b, rs_b;
    logic [15:0] old_f, old_r, avg_f, avg_r;
    n = 9'h001 << eff_log;
    fill_b = (eff_log != eff_log_reg) ? 9'h0 : fill_reg;
    fs_b = (eff_log != eff_log_reg) ? 24'h0 : fsum_reg;
    rs_b = (eff_log != eff_log_reg) ? 24'h0 : rsum_reg;
    old_f = fwd_mem[ptr_reg - n[7:0]];
    old_r = rev_mem[ptr_reg - n[7:0]];
    avg_f = 16'h0;
    avg_r = 16'h0;
    eff_log_next = eff_log;
    ptr_next = ptr_reg;
    fill_next = fill_b;
    fsum_next = fs_b;
    rsum_next = rs_b;
    out_valid_next = 1'b0;
    fwd_res_next = fwd_res_reg;
    rev_res_next = rev_res_reg;
    fwd_level_next = fwd_level_reg;
    if (sample_valid) begin
      ptr_next = ptr_reg + 8'h01;
      if (fill_b >= n) begin
        fsum_next = fs_b + 24'(fwd_sample) - 24'(old_f);
        rsum_next = rs_b + 24'(rev_sample) - 24'(old_r);
      end else begin
        fsum_next = fs_b + 24'(fwd_sample);
        rsum_next = rs_b + 24'(rev_sample);
        fill_next = fill_b + 9'h001;
      end
      if (fill_next >= n) begin
        avg_f = 16'(fsum_next >> eff_log);
        avg_r = 16'(rsum_next >> eff_log);
        out_valid_next = 1'b1;
        fwd_level_next = avg_f;
        fwd_res_next = apply_corr(avg_f, corr_reg);
        rev_res_next = apply_corr(avg_r, corr_reg);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sample_valid) begin
      fwd_mem[ptr_reg] <= fwd_sample;
      rev_mem[ptr_reg] <= rev_sample;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h0;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
      carrier_hz_setting_reg <= CARRIER_HZ_SETTING_DEF;
      smoothing_count_reg <= CNT_DEF;
      smoothing_mode_select_reg <= MODE_AUTO;
      adc_window_time_reg <= INT_DEF_US;
      adc_window_mode_reg <= INT_DEF;
      digit_precision_select_reg <= RES_LOW;
      vid_reg <= vid_medium;
      func_reg <= mean_forward_power;
      eff_log_reg <= 4'h0;
      ptr_reg <= 8'h0;
      fill_reg <= 9'h0;
      fsum_reg <= 24'h0;
      rsum_reg <= 24'h0;
      out_valid_reg <= 1'b0;
      fwd_res_reg <= 16'h0;
      rev_res_reg <= 16'h0;
      fwd_level_reg <= 16'h0;
      corr_reg <= 16'h0;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      carrier_hz_setting_reg <= carrier_hz_setting_next;
      smoothing_count_reg <= smoothing_count_next;
      smoothing_mode_select_reg <= smoothing_mode_select_next;
      adc_window_time_reg <= adc_window_time_next;
      adc_window_mode_reg <= adc_window_mode_next;
      digit_precision_select_reg <= digit_precision_select_next;
      vid_reg <= vid_next;
      func_reg <= func_next;
      eff_log_reg <= eff_log_next;
      ptr_reg <= ptr_next;
      fill_reg <= fill_next;
      fsum_reg <= fsum_next;
      rsum_reg <= rsum_next;
      out_valid_reg <= out_valid_next;
      fwd_res_reg <= fwd_res_next;
      rev_res_reg <= rev_res_next;
      fwd_level_reg <= fwd_level_next;
      corr_reg <= corr_next;
    end
  end

  // results keep one 16-bit format; resolution only steers averaging
  assign fwd_result = fwd_res_reg;
  assign rev_result = rev_res_reg;
  assign out_valid = out_valid_reg;
  assign adc_window_us = eff_time;
  assign detector_bandwidth_select = vid_reg;
  assign forward_function = func_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence wr_to(logic [7:0] off);
    do_write && aw_addr_reg == off && w_strb_reg == STRB_ALL;
  endsequence
  sequence good_count;
    wr_to(OFF_COUNT) ##0 is_pow2(w_data_reg);
  endsequence
  count_legal_a: assert property ($onehot(smoothing_count_reg)
    && smoothing_count_reg <= 9'h100) else $error("bad count");
  count_user_a: assert property (good_count |=>
    smoothing_mode_select_reg == MODE_USER
    && smoothing_count_reg == $past(w_data_reg[8:0])
    ##1 eff_log_reg == cnt_log2(smoothing_count_reg))
    else $error("count entry not applied");
  count_reject_a: assert property (wr_to(OFF_COUNT) ##0
    !is_pow2(w_data_reg) |=> $stable(smoothing_count_reg)
    && $stable(smoothing_mode_select_reg) && bresp == RESP_SLVERR)
    else $error("bad count accepted");
  time_user_a: assert property (wr_to(OFF_INT_TIME) ##0 !wr_err
    |=> adc_window_mode_reg == INT_USER && adc_window_us ==
    $past(w_data_reg[16:0])) else $error("time entry lost");
  res_auto_a: assert property (wr_to(OFF_RES) ##0 !wr_err
    |=> smoothing_mode_select_reg == MODE_AUTO)
    else $error("resolution kept user mode");
  time_default_a: assert property (adc_window_mode_reg == INT_DEF
    |-> adc_window_us == INT_DEF_US) else $error("default time");
  single_pass_a: assert property (sample_valid && eff_log == 4'h0
    |=> out_valid) else $error("count one not immediate");
  running_out_a: assert property (sample_valid && window_full
    && eff_log == eff_log_reg |=> out_valid ##1 !out_valid[*1]
    or sample_valid) else $error("running average stalled");
  // a new count lands one cycle before the applied log2 follows it
  user_apply_a: assert property (smoothing_mode_select_reg == MODE_USER
    ##1 smoothing_mode_select_reg == MODE_USER
    && $stable(smoothing_count_reg)
    |-> eff_log_reg == cnt_log2(smoothing_count_reg))
    else $error("user count not used");
  vid_legal_a: assert property (vid_reg != 2'h3)
    else $error("bad bandwidth code");
endmodule

// [verification/host_model.sv]
// host side: AXI4-Lite master issuing setting writes and reads
// assumes mclk shared with the filter block; calls start after reset
module host_model
  import sensor_filter_pkg::*;
(
  input wire logic mclk,
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic [2:0] awprot,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  output logic [2:0] arprot,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    awprot = 3'h0;
    arprot = 3'h0;
  end
  // ready is sampled mid-cycle: it depends only on registered state here
  // counts above 256 are sent only to probe the accepted set
  task automatic write(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [1:0] r);
    logic aw_hit, w_hit, aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge mclk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      @(posedge mclk);
      if (aw_hit) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
        aw_done = 1'b1;
      end
      if (w_hit) begin
        wvalid <= 1'b0;
        wdata <= ~d;
        w_done = 1'b1;
      end
    end
    aw_hit = 1'b0;
    while (!aw_hit) begin
      @(negedge mclk);
      aw_hit = bvalid;
      r = bresp;
      @(posedge mclk);
    end
    bready <= 1'b0;
  endtask
  // results are taken whole; digit trimming is left to host software
  task automatic read(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    logic hit;
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    hit = 1'b0;
    while (!hit) begin
      @(negedge mclk);
      hit = arready;
      @(posedge mclk);
    end
    arvalid <= 1'b0;
    araddr <= ~a;
    hit = 1'b0;
    while (!hit) begin
      @(negedge mclk);
      hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
    end
    rready <= 1'b0;
  endtask
endmodule

// [verification/power_sensor_filter_control_tb.sv]
// self-checking bench for the measurement filter settings block
// assumes host_model as bus master and samples driven here on mclk
module power_sensor_filter_control_tb
  import sensor_filter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000;
  localparam logic [31:0] DEFS [0:7] = '{32'h3b9aca00, 32'h1, 32'h0,
    32'h9088, 32'h0, 32'h0, 32'h1, 32'h0};
  localparam logic [31:0] VIDS [0:2] = '{VID_4K_HZ, VID_200K_HZ, VID_4M_HZ};
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sample_valid, out_valid;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot, forward_function;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, detector_bandwidth_select, resp;
  logic [31:0] wdata, rdata, data;
  logic [15:0] fwd_sample, rev_sample, fwd_result, rev_result;
  logic [16:0] adc_window_us;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int i;
  always #10 mclk = ~mclk;
  power_sensor_filter_control u_dut (.mclk, .nrst, .awvalid, .awready,
    .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid, .rready, .rdata,
    .rresp, .sample_valid, .fwd_sample, .rev_sample, .out_valid,
    .fwd_result, .rev_result, .adc_window_us, .detector_bandwidth_select,
    .forward_function);
  host_model u_host (.mclk, .awvalid, .awready, .awaddr, .awprot, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .arprot, .rvalid, .rready, .rdata, .rresp);
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] e);
    u_host.write(a, d, s, resp);
    chk({30'h0, resp}, {30'h0, e});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    u_host.read(a, data, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    chk(data, e);
  endtask
  // the full bit is left out: it depends on warm-up progress
  task automatic stat(input logic [31:0] e);
    u_host.read(OFF_STATUS, data, resp);
    chk(data & 32'h6f, e);
  endtask
  // drives the same value on both channels so one expectation serves both
  task automatic feed(input logic [15:0] s, input logic v,
                      input logic [15:0] e);
    @(posedge mclk);
    sample_valid <= 1'b1;
    fwd_sample <= s;
    rev_sample <= s;
    @(posedge mclk);
    sample_valid <= 1'b0;
    @(negedge mclk);
    chk({31'h0, out_valid}, {31'h0, v});
    if (v) begin
      chk({16'h0, fwd_result}, {16'h0, e});
      chk({16'h0, rev_result}, {16'h0, e});
    end
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    sample_valid = 1'b0;
    fwd_sample = 16'h0000;
    rev_sample = 16'h0000;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    chk(32'(adc_window_us), 32'h9088);
    for (i = 0; i < 8; i++) begin
      rchk(8'(i * 4), DEFS[i]);
    end
    chk(32'(detector_bandwidth_select), 32'h1);
    chk(32'(forward_function), 32'h0);
    u_host.read(8'h28, data, resp);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wchk(8'h28, 32'h1, STRB_ALL, RESP_SLVERR);
    wchk(OFF_STATUS, 32'h0, STRB_ALL, RESP_SLVERR);
    wchk(OFF_COUNT, 32'h2, 4'h3, RESP_SLVERR);
    for (i = 0; i < 9; i++) begin
      wchk(OFF_COUNT, 32'h1 << i, STRB_ALL, RESP_OKAY);
      rchk(OFF_COUNT, 32'h1 << i);
    end
    rchk(OFF_AVG_MODE, 32'h1);
    wchk(OFF_COUNT, 32'h3, STRB_ALL, RESP_SLVERR);
    wchk(OFF_COUNT, 32'h200, STRB_ALL, RESP_SLVERR);
    wchk(OFF_COUNT, 32'h0, STRB_ALL, RESP_SLVERR);
    rchk(OFF_COUNT, 32'h100);
    stat(32'h28);
    wchk(OFF_INT_TIME, 32'h1387, STRB_ALL, RESP_SLVERR);
    wchk(OFF_INT_TIME, 32'h1b1fd, STRB_ALL, RESP_SLVERR);
    rchk(OFF_INT_MODE, 32'h0);
    wchk(OFF_INT_TIME, 32'h1388, STRB_ALL, RESP_OKAY);
    rchk(OFF_INT_MODE, 32'h1);
    chk(32'(adc_window_us), 32'h1388);
    wchk(OFF_INT_MODE, 32'h0, STRB_ALL, RESP_OKAY);
    chk(32'(adc_window_us), 32'h9088);
    wchk(OFF_INT_TIME, 32'h1b1fc, STRB_ALL, RESP_OKAY);
    chk(32'(adc_window_us), 32'h1b1fc);
    wchk(OFF_VID, VID_600K_HZ, STRB_ALL, RESP_SLVERR);
    for (i = 0; i < 3; i++) begin
      wchk(OFF_VID, VIDS[i], STRB_ALL, RESP_OKAY);
      chk(32'(detector_bandwidth_select), 32'(i));
    end
    // sensor taken as wired for forward power in the preferred direction
    for (i = 0; i < 6; i++) begin
      wchk(OFF_FUNC, 32'(i), STRB_ALL, RESP_OKAY);
      chk(32'(forward_function), 32'(i));
    end
    wchk(OFF_FUNC, 32'h6, STRB_ALL, RESP_SLVERR);
    chk(32'(forward_function), 32'h5);
    wchk(OFF_FUNC, 32'h0, STRB_ALL, RESP_OKAY);
    wchk(OFF_CARRIER, 32'h0bebc1ff, STRB_ALL, RESP_SLVERR);
    wchk(OFF_CARRIER, 32'h50000000, STRB_ALL, RESP_OKAY);
    rchk(OFF_CORR, 32'h40a0);
    wchk(OFF_CARRIER, 32'h40000000, STRB_ALL, RESP_OKAY);
    rchk(OFF_CORR, 32'h4080);
    wchk(OFF_COUNT, 32'h1, STRB_ALL, RESP_OKAY);
    feed(16'h1000, 1'b1, 16'h1020);
    wchk(OFF_COUNT, 32'h4, STRB_ALL, RESP_OKAY);
    for (i = 1; i < 4; i++) begin
      feed(16'(i * 256), 1'b0, 16'h0000);
    end
    feed(16'h0400, 1'b1, 16'h0285);
    feed(16'h0900, 1'b1, 16'h0489);
    wchk(OFF_RES, 32'h1, STRB_ALL, RESP_OKAY);
    rchk(OFF_AVG_MODE, 32'h0);
    stat(32'h46);
    wchk(OFF_INT_TIME, 32'h1388, STRB_ALL, RESP_OKAY);
    stat(32'h47);
    wchk(OFF_FUNC, 32'h1, STRB_ALL, RESP_OKAY);
    stat(32'h48);
    stop_test();
  end
endmodule
